/* hdl/pport_pkg.sv */
// constants shared by both ends of the byte slave port and its pins
// assumes one clock, mclk at 250 MHz, on both ends
package pport_pkg;
    // register offsets on the device's processor port
    localparam logic [7:0] PARALLEL_PORT_DATA_OFS = 8'h08;
    localparam logic [7:0] CONTROL_PORT_DATA_OFS = 8'h09;
    localparam logic [7:0] PARALLEL_PORT_DIRECTION_OFS = 8'h88;
    localparam logic [7:0] CONTROL_PORT_DIRECTION_STATUS_OFS = 8'h89;
    localparam logic [7:0] ANALOG_PIN_CONFIG_OFS = 8'h9F;

    // fields of control_port_direction_status
    localparam int INPUT_FULL_BIT = 7;
    localparam int OUTPUT_FULL_BIT = 6;
    localparam int INPUT_OVERFLOW_BIT = 5;
    localparam int SLAVE_MODE_BIT = 4;
    localparam int UNUSED_BIT = 3;
    localparam int CTL_DIR_MSB = 2;

    // reset values
    localparam logic [7:0] PARALLEL_PORT_DIRECTION_RST = 8'hFF;
    localparam logic [7:0] CONTROL_PORT_DIRECTION_STATUS_RST = 8'h07;
    localparam logic [2:0] ANALOG_PIN_CONFIG_RST = 3'h0;
    localparam logic [2:0] ALL_ANALOG_CFG = 3'h0;
    localparam logic [7:0] DATA_RST = 8'h00;

    // control pin positions in slave mode
    localparam int READ_STROBE_PIN = 0;
    localparam int WRITE_STROBE_PIN = 1;
    localparam int CHIP_SELECT_PIN = 2;

    // host cycle timing, in mclk cycles
    localparam logic [3:0] STROBE_CYC = 4'hC;
    localparam logic [3:0] HOLD_CYC = 4'h6;
    localparam logic [3:0] GAP_CYC = 4'h6;

    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_STROBE = 4'h2,
        H_HOLD = 4'h4,
        H_GAP = 4'h8
    } host_state_t;
endpackage

/* hdl/pport_if.sv */
// pins between the device's ports and the external microprocessor
// a pin with no driver pulls high
interface pport_if;
    logic [7:0] dev_pd_o;
    logic [7:0] dev_pd_oe_n;
    logic [2:0] dev_ctl_o;
    logic [2:0] dev_ctl_oe_n;
    logic [7:0] host_pd_o;
    logic [7:0] host_pd_oe_n;
    logic [2:0] host_ctl_o;
    logic [2:0] host_ctl_oe_n;
    logic [7:0] pd_bus;
    logic [2:0] ctl_bus;

    assign pd_bus = (~dev_pd_oe_n & dev_pd_o)
        | (dev_pd_oe_n & ~host_pd_oe_n & host_pd_o)
        | (dev_pd_oe_n & host_pd_oe_n);
    assign ctl_bus = (~dev_ctl_oe_n & dev_ctl_o)
        | (dev_ctl_oe_n & ~host_ctl_oe_n & host_ctl_o)
        | (dev_ctl_oe_n & host_ctl_oe_n);

    modport dev (
        input pd_bus, ctl_bus,
        output dev_pd_o, dev_pd_oe_n, dev_ctl_o, dev_ctl_oe_n
    );
    modport host (
        input pd_bus, ctl_bus,
        output host_pd_o, host_pd_oe_n, host_ctl_o, host_ctl_oe_n
    );
endinterface

/* hdl/pport_device.sv */
// device end: 8-bit parallel port, 3-bit control port, byte slave port
// assumes pins arrive unsynchronised through pport_if.dev
// Function
// - eight parallel pins, each with own direction
// - mode bit selects slave port or plain I/O
// - three control pins, one means input
// - software sets control pins digital inputs first
// - analog control pins read back as zero
// - direction bits still apply to analog pins
// - after reset control pins are analog inputs
// - input full set by unread external write
// - output full until external bus reads byte
// - overflow on write while input full
// - bit three reads as zero
// - reset makes all parallel pins inputs
// - selected low read strobe drives output latch
// - selected low write strobe latches pin levels
// - low chip select enables the strobes
// - strobe end latches data, sets flags
// - external read clears output full at once
// - processor read clears input full; overwrite
// - outside slave mode full flags held zero
module pport_device (
    input wire logic mclk,
    input wire logic rstn,
    pport_if.dev pins,
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_we,
    input wire logic cpu_re,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic slave_port_irq_flag,
    output logic [2:0] analog_sel
);
    // pin synchronisers: 8 data pins then 3 control pins
    logic [10:0] pin_s1_r;
    logic [10:0] pin_s2_r;
    logic [10:0] pin_s3_r;
    logic [10:0] pin_f_r;
    logic [10:0] pin_f_nxt;

    logic [7:0] out_latch_r;
    logic [7:0] in_latch_r;
    logic [7:0] in_latch_nxt;
    logic [7:0] pd_dir_r;
    logic [2:0] ctl_dir_r;
    logic [2:0] ctl_out_r;
    logic [2:0] analog_cfg_r;
    logic mode_r;
    logic input_full_r;
    logic input_full_nxt;
    logic output_full_r;
    logic output_full_nxt;
    logic input_overflow_r;
    logic input_overflow_nxt;
    logic wr_act_r;
    logic rd_act_r;
    logic irq_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // one means the pin is selected as an analog input
    function automatic logic [2:0] analog_mask(input logic [2:0] cfg);
        analog_mask = (cfg == pport_pkg::ALL_ANALOG_CFG) ? 3'h7 : 3'h0;
    endfunction

    wire [7:0] pd_f = pin_f_r[7:0];
    wire [2:0] ctl_f = pin_f_r[10:8];
    wire [2:0] ana = analog_mask(analog_cfg_r);
    wire [2:0] ctl_read = ctl_f & ~ana;
    wire cs_low = ~ctl_f[pport_pkg::CHIP_SELECT_PIN];
    wire wr_act = mode_r & cs_low
        & ~ctl_f[pport_pkg::WRITE_STROBE_PIN];
    wire rd_act = mode_r & cs_low
        & ~ctl_f[pport_pkg::READ_STROBE_PIN];
    wire wr_end = wr_act_r & ~wr_act;
    wire rd_end = rd_act_r & ~rd_act;

    wire wr_pd = cpu_we & (cpu_addr == pport_pkg::PARALLEL_PORT_DATA_OFS);
    wire wr_ce = cpu_we & (cpu_addr == pport_pkg::CONTROL_PORT_DATA_OFS);
    wire wr_pdir = cpu_we
        & (cpu_addr == pport_pkg::PARALLEL_PORT_DIRECTION_OFS);
    wire wr_cst = cpu_we
        & (cpu_addr == pport_pkg::CONTROL_PORT_DIRECTION_STATUS_OFS);
    wire wr_ana = cpu_we & (cpu_addr == pport_pkg::ANALOG_PIN_CONFIG_OFS);
    wire rd_pd = cpu_re & (cpu_addr == pport_pkg::PARALLEL_PORT_DATA_OFS);

    wire [7:0] status_word = {input_full_r, output_full_r,
        input_overflow_r, mode_r, 1'b0, ctl_dir_r};

    // a change counts once the second and third stages agree
    assign pin_f_nxt = (pin_s2_r & pin_s3_r)
        | (pin_f_r & (pin_s2_r | pin_s3_r));

    // write end latches pins; a repeat write overwrites
    assign in_latch_nxt = wr_end ? pd_f : in_latch_r;

    always_comb begin
        input_full_nxt = input_full_r;
        if (!mode_r) begin
            input_full_nxt = 1'b0;
        end else if (wr_end) begin
            input_full_nxt = 1'b1;
        end else if (rd_pd) begin
            input_full_nxt = 1'b0;
        end
    end

    // an external read in progress keeps the flag low
    always_comb begin
        output_full_nxt = output_full_r;
        if (!mode_r) begin
            output_full_nxt = 1'b0;
        end else if (rd_act) begin
            output_full_nxt = 1'b0;
        end else if (wr_pd) begin
            output_full_nxt = 1'b1;
        end
    end

    // hardware set wins over software write
    always_comb begin
        input_overflow_nxt = input_overflow_r;
        if (wr_cst) begin
            input_overflow_nxt =
                cpu_wdata[pport_pkg::INPUT_OVERFLOW_BIT];
        end
        if (wr_end && input_full_r) begin
            input_overflow_nxt = 1'b1;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        case (cpu_addr)
            pport_pkg::PARALLEL_PORT_DATA_OFS:
                rdata_nxt = mode_r ? in_latch_r : pd_f;
            pport_pkg::CONTROL_PORT_DATA_OFS:
                rdata_nxt = {5'h00, ctl_read};
            pport_pkg::PARALLEL_PORT_DIRECTION_OFS:
                rdata_nxt = pd_dir_r;
            pport_pkg::CONTROL_PORT_DIRECTION_STATUS_OFS:
                rdata_nxt = status_word;
            pport_pkg::ANALOG_PIN_CONFIG_OFS:
                rdata_nxt = {5'h00, analog_cfg_r};
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        pin_s1_r <= {pins.ctl_bus, pins.pd_bus};
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        pin_f_r <= pin_f_nxt;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pd_dir_r <= pport_pkg::PARALLEL_PORT_DIRECTION_RST;
            ctl_dir_r <= pport_pkg::CONTROL_PORT_DIRECTION_STATUS_RST
                [pport_pkg::CTL_DIR_MSB:0];
            mode_r <= 1'b0;
            analog_cfg_r <= pport_pkg::ANALOG_PIN_CONFIG_RST;
        end else begin
            if (wr_pdir) begin
                pd_dir_r <= cpu_wdata;
            end
            if (wr_cst) begin
                ctl_dir_r <= cpu_wdata[pport_pkg::CTL_DIR_MSB:0];
                mode_r <= cpu_wdata[pport_pkg::SLAVE_MODE_BIT];
            end
            if (wr_ana) begin
                analog_cfg_r <= cpu_wdata[2:0];
            end
        end
    end

    // status flags follow slave-port events, processor reads and writes, and the mode bit
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            input_full_r <= 1'b0;
            output_full_r <= 1'b0;
            input_overflow_r <= 1'b0;
            wr_act_r <= 1'b0;
            rd_act_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            input_full_r <= input_full_nxt;
            output_full_r <= output_full_nxt;
            input_overflow_r <= input_overflow_nxt;
            wr_act_r <= wr_act;
            rd_act_r <= rd_act;
            irq_r <= wr_end | rd_end;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            out_latch_r <= pport_pkg::DATA_RST;
            in_latch_r <= pport_pkg::DATA_RST;
            ctl_out_r <= 3'h0;
            rdata_r <= 8'h00;
        end else begin
            if (wr_pd) begin
                out_latch_r <= cpu_wdata;
            end
            if (wr_ce) begin
                ctl_out_r <= cpu_wdata[2:0];
            end
            in_latch_r <= in_latch_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cpu_rdata = rdata_r;
    assign slave_port_irq_flag = irq_r;
    assign analog_sel = ana;

    assign pins.dev_pd_o = out_latch_r;
    // slave mode ignores the direction register
    assign pins.dev_pd_oe_n = mode_r ? {8{~rd_act}} : pd_dir_r;
    assign pins.dev_ctl_o = ctl_out_r;
    // direction applies even to analog pins
    assign pins.dev_ctl_oe_n = ctl_dir_r;
endmodule

/* hdl/pport_host.sv */
// far end: external microprocessor issuing byte reads and writes
// assumes the device is in slave mode with control pins as inputs
module pport_host (
    input wire logic mclk,
    input wire logic rstn,
    pport_if.host pins,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data
);
    pport_pkg::host_state_t state_r;
    pport_pkg::host_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic is_wr_r;
    logic [7:0] wdata_r;
    logic [7:0] pd_s1_r;
    logic [7:0] pd_s2_r;
    logic [7:0] pd_s3_r;
    logic [7:0] pd_f_r;
    logic rsp_valid_r;
    logic [7:0] rsp_data_r;

    wire in_strobe = (state_r == pport_pkg::H_STROBE);
    wire cnt_done = (cnt_r == 4'h0);
    wire strobe_last = in_strobe & cnt_done;
    wire drive_pd = is_wr_r & (in_strobe | state_r == pport_pkg::H_HOLD);

    assign req_ready = (state_r == pport_pkg::H_IDLE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_done ? 4'h0 : cnt_r - 4'h1;
        case (state_r)
            pport_pkg::H_IDLE: begin
                if (req_valid) begin
                    state_nxt = pport_pkg::H_STROBE;
                    cnt_nxt = pport_pkg::STROBE_CYC - 4'h1;
                end
            end
            pport_pkg::H_STROBE: begin
                if (cnt_done) begin
                    state_nxt = pport_pkg::H_HOLD;
                    cnt_nxt = pport_pkg::HOLD_CYC - 4'h1;
                end
            end
            pport_pkg::H_HOLD: begin
                if (cnt_done) begin
                    state_nxt = pport_pkg::H_GAP;
                    cnt_nxt = pport_pkg::GAP_CYC - 4'h1;
                end
            end
            pport_pkg::H_GAP: begin
                if (cnt_done) begin
                    state_nxt = pport_pkg::H_IDLE;
                end
            end
            default: begin
                state_nxt = pport_pkg::H_IDLE;
                cnt_nxt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        pd_s1_r <= pins.pd_bus;
        pd_s2_r <= pd_s1_r;
        pd_s3_r <= pd_s2_r;
        pd_f_r <= (pd_s2_r & pd_s3_r) | (pd_f_r & (pd_s2_r | pd_s3_r));
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= pport_pkg::H_IDLE;
            cnt_r <= 4'h0;
            is_wr_r <= 1'b0;
            wdata_r <= 8'h00;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (req_ready && req_valid) begin
                is_wr_r <= req_write;
                wdata_r <= req_wdata;
            end
            rsp_valid_r <= strobe_last & ~is_wr_r;
            if (strobe_last && !is_wr_r) begin
                rsp_data_r <= pd_f_r;
            end
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_data = rsp_data_r;

    // chip select with one strobe, both released together
    assign pins.host_ctl_o[pport_pkg::CHIP_SELECT_PIN] = ~in_strobe;
    assign pins.host_ctl_o[pport_pkg::WRITE_STROBE_PIN] =
        ~(in_strobe & is_wr_r);
    assign pins.host_ctl_o[pport_pkg::READ_STROBE_PIN] =
        ~(in_strobe & ~is_wr_r);
    assign pins.host_ctl_oe_n = 3'h0;
    assign pins.host_pd_o = wdata_r;
    assign pins.host_pd_oe_n = {8{~drive_pd}};
endmodule

/* dv/pport_assertions.sv */
// pin-level checks on the link between device and host ends
// assumes an instance beside the pport_if in the bench top
module pport_checker (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] dev_pd_oe_n,
    input wire logic [2:0] dev_ctl_oe_n,
    input wire logic [7:0] host_pd_o,
    input wire logic [7:0] host_pd_oe_n,
    input wire logic [2:0] host_ctl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_dev_reset_inputs: assert property (
        $rose(rstn) |-> dev_pd_oe_n == 8'hFF && dev_ctl_oe_n == 3'h7)
        else $error("device pins not inputs after reset");
    a_host_reset_idle: assert property (
        $rose(rstn) |-> host_ctl_o == 3'h7 && host_pd_oe_n == 8'hFF)
        else $error("host strobes not idle after reset");
    a_no_bus_fight: assert property (
        (~dev_pd_oe_n & ~host_pd_oe_n) == 8'h00)
        else $error("both ends drive the data pins");
    a_strobe_needs_select: assert property (
        (!host_ctl_o[0] || !host_ctl_o[1]) |-> !host_ctl_o[2])
        else $error("strobe low without chip select");
    a_read_write_apart: assert property (
        host_ctl_o[0] || host_ctl_o[1])
        else $error("read and write strobes low together");
    a_select_length: assert property (
        $fell(host_ctl_o[2]) |-> !host_ctl_o[2] [*8])
        else $error("chip select too short");
    a_write_data_hold: assert property (
        $rose(host_ctl_o[1]) |->
            (host_pd_oe_n == 8'h00 && $stable(host_pd_o)) [*5])
        else $error("write data not held after strobe");
    a_read_drives_pins: assert property (
        $fell(host_ctl_o[0]) |-> ##[2:8] dev_pd_oe_n == 8'h00)
        else $error("device does not drive on external read");
    a_read_releases_pins: assert property (
        $rose(host_ctl_o[0]) |-> ##[2:8] dev_pd_oe_n == 8'hFF)
        else $error("device keeps driving after read");

    c_ext_write: cover property ($rose(host_ctl_o[1]));
    c_ext_read: cover property ($rose(host_ctl_o[0]));
    c_gpio_drive: cover property (dev_pd_oe_n == 8'hF0);
endmodule

/* dv/parallel_port_and_control_pins_tb.sv */
// self-checking bench: device and host ends joined by pport_if
// assumes the cpu register port and host request port of the notes
module parallel_port_and_control_pins_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] cpu_addr = 8'h00;
    logic cpu_we = 1'b0;
    logic cpu_re = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic slave_port_irq_flag;
    logic [2:0] analog_sel;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] q = 8'h00;
    logic [7:0] irq_n = 8'h00;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    pport_if bus ();
    pport_device pport_device_inst (.mclk(mclk), .rstn(rstn), .pins(bus),
        .cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_re(cpu_re),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .slave_port_irq_flag(slave_port_irq_flag), .analog_sel(analog_sel));
    pport_host pport_host_inst (.mclk(mclk), .rstn(rstn), .pins(bus),
        .req_valid(req_valid), .req_write(req_write),
        .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    pport_checker pport_checker_inst (.mclk(mclk), .rstn(rstn),
        .dev_pd_oe_n(bus.dev_pd_oe_n), .dev_ctl_oe_n(bus.dev_ctl_oe_n),
        .host_pd_o(bus.host_pd_o), .host_pd_oe_n(bus.host_pd_oe_n),
        .host_ctl_o(bus.host_ctl_o));

    always #2 mclk = ~mclk;

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // cycle ceiling and interrupt pulse count, mid-cycle when settled
    always @(negedge mclk) begin
        cycles++;
        if (slave_port_irq_flag === 1'b1) irq_n <= irq_n + 8'h01;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] e,
        input logic [7:0] got);
        n_compared++;
        if (got !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpu_we <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge mclk);
        cpu_we <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        cpu_re <= 1'b1;
        cpu_addr <= a;
        @(posedge mclk);
        cpu_re <= 1'b0;
        #1;
        check($sformatf("reg %h", a), e, cpu_rdata);
    endtask

    // one host transfer; returns once the host is idle again
    task automatic host_op(input logic wr, input logic [7:0] d);
        int n;
        logic got;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_wdata <= d;
        @(posedge mclk);
        req_valid <= 1'b0;
        got = wr;
        n = 0;
        #1;
        while (n < 200 && !(got && req_ready === 1'b1)) begin
            @(posedge mclk);
            #1;
            n++;
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                q = rsp_data;
            end
        end
        check("host done", 8'h01, {7'h00, got && req_ready === 1'b1});
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(8'h89, 8'h07);
        rd_chk(8'h88, 8'hFF);
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h00, 8'h00);
        check("analog_sel", 8'h07, {5'h00, analog_sel});
        reg_wr(8'h88, 8'hF0);
        reg_wr(8'h08, 8'hA5);
        repeat (4) @(posedge mclk);
        rd_chk(8'h08, 8'hF5);
        check("pd_oe_n", 8'hF0, bus.dev_pd_oe_n);
        reg_wr(8'h89, 8'hCA);
        reg_wr(8'h09, 8'h04);
        repeat (4) @(posedge mclk);
        check("ctl_oe_n", 8'h02, {5'h00, bus.dev_ctl_oe_n});
        check("ctl_bus", 8'h06, {5'h00, bus.ctl_bus});
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h89, 8'h02);
        reg_wr(8'h9F, 8'h01);
        repeat (4) @(posedge mclk);
        rd_chk(8'h09, 8'h06);
        check("analog_sel", 8'h00, {5'h00, analog_sel});
        // slave mode with the direction register set to outputs
        reg_wr(8'h88, 8'h00);
        reg_wr(8'h89, 8'h17);
        rd_chk(8'h89, 8'h17);
        check("pd_oe_n", 8'hFF, bus.dev_pd_oe_n);
        reg_wr(8'h88, 8'hFF);
        host_op(1'b1, 8'h3C);
        check("irq", 8'h01, irq_n);
        rd_chk(8'h89, 8'h97);
        rd_chk(8'h08, 8'h3C);
        rd_chk(8'h89, 8'h17);
        host_op(1'b1, 8'h11);
        host_op(1'b1, 8'h22);
        rd_chk(8'h89, 8'hB7);
        rd_chk(8'h08, 8'h22);
        rd_chk(8'h89, 8'h37);
        reg_wr(8'h89, 8'hD7);
        rd_chk(8'h89, 8'h17);
        reg_wr(8'h08, 8'h5A);
        rd_chk(8'h89, 8'h57);
        host_op(1'b0, 8'h00);
        check("rsp_data", 8'h5A, q);
        check("irq", 8'h04, irq_n);
        rd_chk(8'h89, 8'h17);
        // leave slave mode with both full flags set
        host_op(1'b1, 8'h44);
        reg_wr(8'h08, 8'h66);
        rd_chk(8'h89, 8'hD7);
        reg_wr(8'h89, 8'h27);
        rd_chk(8'h89, 8'h27);
        host_op(1'b1, 8'h77);
        rd_chk(8'h89, 8'h27);
        check("irq", 8'h05, irq_n);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(8'h88, 8'hFF);
        rd_chk(8'h89, 8'h07);
        print_verdict();
    end
endmodule
